// [rtl/srfl_pkg.sv]
// Purpose: shared types and constants of the switch route filter and lock tracker
// Assumes: port 0 is the upstream port, ports 1..NPORT-1 are downstream
// Notes: descriptors carry only what routing and locking need
package srfl_pkg;
  localparam int NPORT = 7;
  localparam int PW = 3;
  localparam logic [PW-1:0] UP_PORT = 3'h0;
  localparam int FIFO_DEPTH = 8;

  typedef logic [3:0] srfl_kind_t;
  localparam srfl_kind_t KIND_MWR = 4'h0;
  localparam srfl_kind_t KIND_MRD = 4'h1;
  localparam srfl_kind_t KIND_CPL = 4'h2;
  localparam srfl_kind_t KIND_MRDLK = 4'h3;
  localparam srfl_kind_t KIND_CPLDLK = 4'h4;
  localparam srfl_kind_t KIND_CPLLK = 4'h5;
  localparam srfl_kind_t KIND_UNLOCK = 4'h6;
  localparam srfl_kind_t KIND_MSG = 4'h7;

  typedef logic [NPORT-1:0] srfl_pvec_t;
  localparam srfl_pvec_t PVEC_ZERO = 7'h00;

  typedef struct packed {
    logic [PW-1:0] src;
    logic [PW-1:0] dst;
    srfl_kind_t kind;
  } srfl_desc_t;

  localparam int DESC_W = $bits(srfl_desc_t);
  localparam srfl_desc_t DESC_ZERO = 10'h000;

  typedef struct packed {
    srfl_desc_t desc;
    logic ur;
  } srfl_dec_t;

  localparam srfl_dec_t DEC_ZERO = 11'h000;

  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_DOWN = 3'b010,
    LK_SWITCH = 3'b100
  } srfl_lock_t;
endpackage

// [rtl/srfl_route_lock.sv]
// Purpose: route filter and bus-lock tracker for a multi-port switch
// Assumes: descriptors arrive in order per source; posted-pending vectors come from the queues
// Notes: blocked TLPs wait at the FIFO head, so back-pressure reaches the source
// Operation
// - Peer disable makes every downstream-to-other-downstream TLP an unsupported request.
// - Each port holds a route-disable mask, bit n meaning port n.
// - A set mask bit answers TLPs on that route as unsupported requests.
// - Mask never blocks self, upstream-bound or upstream-sourced routes.
// - Only one locked sequence is tracked at any time.
// - MRdLk from upstream locks the target port against all but upstream.
// - MRdLk waits for posted requests queued to its target port.
// - A locked downstream port alone blocks nothing bound for other ports.
// - CplDLk from the locked port locks upstream against other downstream ports.
// - Whole-switch lock holds others toward upstream or locked port until unlock.
// - CplDLk waits for posted requests queued from that port toward upstream.
// - Unlock after a failed attempt releases the pending lock.
// - Configuration stays writable and effective while locked.
// - Further locked reads, writes and their completions leave lock state alone.
// - Upstream and locked ports may still emit messages and MSIs.
// - Unlock goes to the locked port after posted requests queued to that port drain.
// - A blocked TLP is held, never dropped, until reset, since the Unlock queues behind it.
`timescale 1ns/10ps
`default_nettype none

module srfl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic [AW:0] nxt_cnt;
  logic room_ff;
  logic empty_ff;
  logic push;
  logic pop;

  assign push = in_valid && room_ff;
  assign pop = out_ready && !empty_ff;
  assign in_ready = room_ff;
  assign out_valid = !empty_ff;
  assign out_data = mem[rd_ptr_ff];

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + CNT_ONE;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // Flags are registered so that ready and valid never ripple through the counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
      room_ff <= 1'b1;
      empty_ff <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + PTR_ONE;
      end
      cnt_ff <= nxt_cnt;
      room_ff <= (nxt_cnt != CNT_FULL);
      empty_ff <= (nxt_cnt == '0);
    end
  end
endmodule

module srfl_route_lock (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tlp_valid,
  input wire srfl_pkg::srfl_desc_t tlp_desc,
  output logic tlp_ready,
  input wire logic peer_route_global_disable,
  input wire srfl_pkg::srfl_pvec_t [srfl_pkg::NPORT-1:0] route_disable_mask,
  input wire srfl_pkg::srfl_pvec_t dn_posted_pend,
  input wire srfl_pkg::srfl_pvec_t up_posted_pend,
  output logic dec_valid,
  output srfl_pkg::srfl_dec_t dec_out,
  input wire logic dec_ready,
  output logic sw_locked,
  output logic dn_locked,
  output logic [srfl_pkg::PW-1:0] locked_port,
  output logic hold_active
);
  import srfl_pkg::*;

  function automatic logic is_dn(input logic [PW-1:0] p);
    return p != UP_PORT;
  endfunction

  function automatic logic is_peer(input srfl_desc_t d);
    return is_dn(d.src) && is_dn(d.dst) && (d.src != d.dst);
  endfunction

  logic hv;
  srfl_desc_t head;
  logic [DESC_W-1:0] head_raw;
  logic pop;
  logic lock_block;
  logic order_wait;
  logic hold;
  logic take;
  logic route_ur;
  srfl_lock_t lock_st_ff;
  srfl_lock_t nxt_lock_st;
  logic [PW-1:0] lock_port_ff;
  logic [PW-1:0] nxt_lock_port;
  logic dec_valid_ff;
  srfl_dec_t dec_ff;
  logic sw_locked_ff;
  logic dn_locked_ff;
  logic hold_ff;

  srfl_fifo #(
    .WIDTH(DESC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(tlp_valid),
    .in_ready(tlp_ready),
    .in_data(tlp_desc),
    .out_valid(hv),
    .out_ready(pop),
    .out_data(head_raw)
  );

  assign head = srfl_desc_t'(head_raw);

  // Lock blocking checks both the source and the destination against the locked ports
  always_comb begin
    lock_block = 1'b0;
    if (lock_st_ff != LK_IDLE && head.dst == lock_port_ff && head.src != UP_PORT) begin
      lock_block = 1'b1;
    end
    if (lock_st_ff == LK_SWITCH && head.dst == UP_PORT && is_dn(head.src)
      && head.src != lock_port_ff) begin
      lock_block = 1'b1;
    end
  end

  // MRdLk, CplDLk and Unlock may pass non-posted and completions but never posted writes; CplLk is not held
  always_comb begin
    order_wait = 1'b0;
    if (head.kind == KIND_MRDLK && head.src == UP_PORT && dn_posted_pend[head.dst]) begin
      order_wait = 1'b1;
    end
    if (head.kind == KIND_CPLDLK && up_posted_pend[head.src]) begin
      order_wait = 1'b1;
    end
    if (head.kind == KIND_UNLOCK && lock_st_ff != LK_IDLE && dn_posted_pend[lock_port_ff]) begin
      order_wait = 1'b1;
    end
  end

  // Mask and global disable are read live, so side-port writes act even while locked
  always_comb begin
    route_ur = 1'b0;
    if (is_peer(head)) begin
      route_ur = peer_route_global_disable || route_disable_mask[head.src][head.dst];
    end
  end

  assign hold = lock_block || order_wait;
  assign take = hv && !hold && (!dec_valid_ff || dec_ready);
  assign pop = take;

  always_comb begin
    nxt_lock_st = lock_st_ff;
    nxt_lock_port = lock_port_ff;
    if (take) begin
      case (lock_st_ff)
        LK_IDLE: begin
          if (head.kind == KIND_MRDLK && head.src == UP_PORT && is_dn(head.dst)) begin
            nxt_lock_st = LK_DOWN;
            nxt_lock_port = head.dst;
          end
        end
        LK_DOWN: begin
          if (head.kind == KIND_CPLDLK && head.src == lock_port_ff) begin
            nxt_lock_st = LK_SWITCH;
          end else if (head.kind == KIND_UNLOCK && head.src == UP_PORT) begin
            nxt_lock_st = LK_IDLE;
          end
        end
        LK_SWITCH: begin
          // CplLk, MRdLk and MWr here leave the lock as it is
          if (head.kind == KIND_UNLOCK && head.src == UP_PORT) begin
            nxt_lock_st = LK_IDLE;
          end
        end
        default: begin
          nxt_lock_st = LK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_st_ff <= LK_IDLE;
      lock_port_ff <= UP_PORT;
      sw_locked_ff <= 1'b0;
      dn_locked_ff <= 1'b0;
    end else begin
      lock_st_ff <= nxt_lock_st;
      lock_port_ff <= nxt_lock_port;
      sw_locked_ff <= (nxt_lock_st == LK_SWITCH);
      dn_locked_ff <= (nxt_lock_st != LK_IDLE);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dec_valid_ff <= 1'b0;
      dec_ff <= DEC_ZERO;
    end else if (take) begin
      dec_valid_ff <= 1'b1;
      dec_ff.desc <= head;
      dec_ff.ur <= route_ur;
      if (head.kind == KIND_UNLOCK && lock_st_ff != LK_IDLE) begin
        dec_ff.desc.dst <= lock_port_ff;
      end
    end else if (dec_ready) begin
      dec_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= hv && hold;
    end
  end

  assign dec_valid = dec_valid_ff;
  assign dec_out = dec_ff;
  assign sw_locked = sw_locked_ff;
  assign dn_locked = dn_locked_ff;
  assign locked_port = lock_port_ff;
  assign hold_active = hold_ff;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_peer_global;
    take && peer_route_global_disable && is_peer(head) |=> dec_valid && dec_out.ur;
  endproperty
  a_peer_global: assert property (p_peer_global) else $error("peer TLP not refused");

  property p_mask;
    take && is_peer(head) && route_disable_mask[head.src][head.dst] |=> dec_out.ur;
  endproperty
  a_mask: assert property (p_mask) else $error("masked route not refused");

  property p_mask_limit;
    dec_valid && !is_peer(dec_out.desc) |-> !dec_out.ur;
  endproperty
  a_mask_limit: assert property (p_mask_limit) else $error("non-peer route refused");

  property p_one_lock;
    $onehot(lock_st_ff) && (dn_locked == (lock_st_ff != LK_IDLE));
  endproperty
  a_one_lock: assert property (p_one_lock) else $error("lock state corrupt");

  property p_lock_down;
    take && lock_st_ff == LK_IDLE && head.kind == KIND_MRDLK && head.src == UP_PORT
      && is_dn(head.dst) |=> dn_locked && !sw_locked && locked_port == $past(head.dst);
  endproperty
  a_lock_down: assert property (p_lock_down) else $error("MRdLk did not lock port");

  property p_mrdlk_order;
    hv && head.kind == KIND_MRDLK && head.src == UP_PORT && dn_posted_pend[head.dst] |-> !take;
  endproperty
  a_mrdlk_order: assert property (p_mrdlk_order) else $error("MRdLk passed posted");

  property p_down_only;
    lock_st_ff == LK_DOWN && hv && head.dst != lock_port_ff |-> !lock_block;
  endproperty
  a_down_only: assert property (p_down_only) else $error("other port blocked");

  property p_up_free;
    hv && head.src == UP_PORT |-> !lock_block;
  endproperty
  a_up_free: assert property (p_up_free) else $error("upstream TLP blocked");

  property p_sw_lock;
    take && lock_st_ff == LK_DOWN && head.kind == KIND_CPLDLK && head.src == lock_port_ff
      |=> sw_locked ##1 sw_locked || !dn_locked;
  endproperty
  a_sw_lock: assert property (p_sw_lock) else $error("CplDLk did not lock switch");

  property p_sw_block;
    lock_st_ff == LK_SWITCH && hv && head.src != UP_PORT && head.src != lock_port_ff
      && (head.dst == UP_PORT || head.dst == lock_port_ff) |-> !take;
  endproperty
  a_sw_block: assert property (p_sw_block) else $error("locked target reached");

  property p_cpl_order;
    hv && head.kind == KIND_CPLDLK && up_posted_pend[head.src] |-> !take;
  endproperty
  a_cpl_order: assert property (p_cpl_order) else $error("CplDLk passed posted");

  property p_fail_release;
    take && lock_st_ff == LK_DOWN && head.kind == KIND_UNLOCK && head.src == UP_PORT
      |=> !dn_locked && dec_out.desc.dst == $past(lock_port_ff);
  endproperty
  a_fail_release: assert property (p_fail_release) else $error("failed lock kept");

  property p_keep_lock;
    take && lock_st_ff == LK_SWITCH && head.kind != KIND_UNLOCK |=> $stable(lock_st_ff);
  endproperty
  a_keep_lock: assert property (p_keep_lock) else $error("lock changed");

  property p_unlock_order;
    hv && head.kind == KIND_UNLOCK && dn_locked && dn_posted_pend[lock_port_ff] |-> !take;
  endproperty
  a_unlock_order: assert property (p_unlock_order) else $error("Unlock passed posted");

  property p_held;
    hv && hold |=> hv && $stable(head_raw);
  endproperty
  a_held: assert property (p_held) else $error("blocked TLP dropped");

  c_full_lock: cover property (take && lock_st_ff == LK_SWITCH && head.kind == KIND_UNLOCK);
  c_fail_lock: cover property (take && lock_st_ff == LK_DOWN && head.kind == KIND_UNLOCK);
  c_peer_ur: cover property (dec_valid && dec_out.ur);
  c_fifo_full: cover property (!tlp_ready && dec_valid && !dec_ready);
endmodule

`default_nettype wire

// [verif/srfl_sink_model.sv]
// Purpose: consumer of route decisions standing in for the egress buses
// Assumes: one decision is taken at each edge where ready and valid are high
// Notes: own shift register, so its stalls are unrelated to the bench stimulus
`timescale 1ns/10ps
`default_nettype none
module srfl_sink_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic stall_all,
  input wire logic stall_rnd,
  output logic dec_ready
);
  logic [31:0] sh_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sh_ff <= 32'h0000_5a5a;
      dec_ready <= 1'b0;
    end else begin
      sh_ff <= {sh_ff[30:0], sh_ff[31] ^ sh_ff[21] ^ sh_ff[1] ^ sh_ff[0]};
      dec_ready <= !stall_all && (!stall_rnd || sh_ff[0] || sh_ff[3]);
    end
  end
endmodule
`default_nettype wire

// [verif/srfl_route_lock_tb.sv]
// Purpose: self-checking bench of the route filter and lock tracker
// Assumes: model state follows decisions in consumption order
// Notes: a head blocked by the lock holds the single queue, so those held cases end in a reset
`timescale 1ns/10ps
`default_nettype none
module srfl_route_lock_tb;
  import srfl_pkg::*;
  logic clk_sys, rst_n, tlp_valid, tlp_ready, peer_route_global_disable;
  logic dec_valid, dec_ready, sw_locked, dn_locked, hold_active, stall_all, stall_rnd;
  srfl_desc_t tlp_desc, e, cur;
  srfl_pvec_t [NPORT-1:0] route_disable_mask;
  srfl_pvec_t dn_posted_pend, up_posted_pend;
  srfl_dec_t dec_out;
  logic [PW-1:0] locked_port, m_lp;
  logic eur;
  bit m_dn, m_sw;
  int n_errors, n_checks, b, i, j;
  logic [31:0] seed;
  srfl_desc_t exp_q[$];
  srfl_kind_t kinds[4] = '{KIND_MWR, KIND_MRD, KIND_CPL, KIND_MSG};

  srfl_route_lock i_srfl_route_lock (.clk_sys(clk_sys), .rst_n(rst_n), .tlp_valid(tlp_valid),
    .tlp_desc(tlp_desc), .tlp_ready(tlp_ready),
    .peer_route_global_disable(peer_route_global_disable),
    .route_disable_mask(route_disable_mask), .dn_posted_pend(dn_posted_pend),
    .up_posted_pend(up_posted_pend), .dec_valid(dec_valid), .dec_out(dec_out),
    .dec_ready(dec_ready), .sw_locked(sw_locked), .dn_locked(dn_locked),
    .locked_port(locked_port), .hold_active(hold_active));
  srfl_sink_model i_srfl_sink_model (.clk_sys(clk_sys), .rst_n(rst_n), .stall_all(stall_all),
    .stall_rnd(stall_rnd), .dec_ready(dec_ready));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic srfl_desc_t mk(input int s, input int d, input srfl_kind_t k);
    return '{src: PW'(s), dst: PW'(d), kind: k};
  endfunction

  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Request held until the edge that samples tlp_ready high
  task automatic send(input srfl_desc_t d);
    @(posedge clk_sys);
    tlp_valid <= 1'b1;
    tlp_desc <= d;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk_sys);
      if (tlp_ready === 1'b1) break;
    end
    exp_q.push_back(d);
    tlp_valid <= 1'b0;
  endtask

  task automatic drain();
    for (int k = 0; k < 300 && exp_q.size() > 0; k++) @(posedge clk_sys);
    chk(exp_q.size() == 0, "decision missing");
    repeat (2) @(posedge clk_sys);
  endtask

  // Locked port is only meaningful while a lock stands
  task automatic lk(input bit dn, input bit sw, input int lp);
    chk(dn_locked === dn && sw_locked === sw && (!dn || locked_port === PW'(lp)), "lock state");
  endtask

  task automatic held();
    repeat (6) @(posedge clk_sys);
    chk(hold_active === 1'b1 && exp_q.size() > 0, "head not held");
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    tlp_valid <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    exp_q.delete();
    m_dn = 0;
    m_sw = 0;
    m_lp = '0;
    @(posedge clk_sys);
    chk(tlp_ready === 1'b1 && dec_valid === 1'b0 && dn_locked === 1'b0 && sw_locked === 1'b0
      && locked_port === '0 && hold_active === 1'b0, "reset state");
  endtask

  always @(posedge clk_sys) begin
    if (rst_n === 1'b1 && dec_valid === 1'b1 && dec_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(1'b0, "unexpected decision");
      end else begin
        e = exp_q.pop_front();
        eur = e.src != UP_PORT && e.dst != UP_PORT && e.src != e.dst
          && (peer_route_global_disable || route_disable_mask[e.src][e.dst]);
        if (e.kind == KIND_UNLOCK && e.src == UP_PORT && m_dn) e.dst = m_lp;
        chk(dec_out === {e, eur}, "decision");
        if (e.kind == KIND_MRDLK && e.src == UP_PORT && !m_dn) begin
          m_dn = 1;
          m_lp = e.dst;
        end
        if (e.kind == KIND_CPLDLK && m_dn && e.src == m_lp) m_sw = 1;
        if (e.kind == KIND_UNLOCK && e.src == UP_PORT) begin
          m_dn = 0;
          m_sw = 0;
        end
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    tlp_valid = 1'b0;
    tlp_desc = DESC_ZERO;
    peer_route_global_disable = 1'b0;
    route_disable_mask = '0;
    dn_posted_pend = PVEC_ZERO;
    up_posted_pend = PVEC_ZERO;
    stall_all = 1'b0;
    stall_rnd = 1'b0;
    seed = 32'h9793;
    n_errors = 0;
    n_checks = 0;
    do_reset();
    stall_rnd <= 1'b1;
    for (b = 0; b < 6; b++) begin
      peer_route_global_disable <= b[0];
      for (i = 0; i < NPORT; i++) begin
        seed = xs(seed);
        route_disable_mask[i] <= seed[NPORT-1:0];
      end
      for (i = 0; i < 20; i++) begin
        seed = xs(seed);
        send(mk(seed[7:0] % 7, seed[15:8] % 7, kinds[seed[17:16]]));
      end
      drain();
    end
    $display("test routing done");
    peer_route_global_disable <= 1'b0;
    route_disable_mask <= '0;
    stall_all <= 1'b1;
    cur = mk(1, 0, KIND_MWR);
    tlp_desc <= cur;
    tlp_valid <= 1'b1;
    repeat (14) begin
      @(posedge clk_sys);
      if (tlp_ready === 1'b1) begin
        exp_q.push_back(cur);
        seed = xs(seed);
        cur = mk(seed[3:0] % 7, 0, KIND_MWR);
        tlp_desc <= cur;
      end
    end
    tlp_valid <= 1'b0;
    chk(tlp_ready === 1'b0 && exp_q.size() >= FIFO_DEPTH, "queue never full");
    stall_all <= 1'b0;
    drain();
    $display("test queue done");
    dn_posted_pend <= 7'h08;
    send(mk(0, 3, KIND_MRDLK));
    held();
    dn_posted_pend <= PVEC_ZERO;
    drain();
    lk(1, 0, 3);
    send(mk(2, 0, KIND_MWR));
    send(mk(2, 4, KIND_MRD));
    drain();
    up_posted_pend <= 7'h08;
    send(mk(3, 0, KIND_CPLDLK));
    held();
    up_posted_pend <= PVEC_ZERO;
    drain();
    lk(1, 1, 3);
    route_disable_mask[2] <= 7'h10;
    send(mk(0, 3, KIND_MRDLK));
    send(mk(3, 0, KIND_CPLLK));
    send(mk(0, 3, KIND_MWR));
    send(mk(3, 0, KIND_MSG));
    send(mk(0, 3, KIND_MSG));
    send(mk(2, 4, KIND_MWR));
    drain();
    lk(1, 1, 3);
    dn_posted_pend <= 7'h08;
    send(mk(0, 0, KIND_UNLOCK));
    held();
    dn_posted_pend <= PVEC_ZERO;
    drain();
    lk(0, 0, 0);
    send(mk(0, 5, KIND_MRDLK));
    send(mk(5, 0, KIND_CPLLK));
    drain();
    lk(1, 0, 5);
    send(mk(0, 0, KIND_UNLOCK));
    drain();
    lk(0, 0, 0);
    $display("test lock done");
    for (j = 0; j < 2; j++) begin
      send(mk(0, 3, KIND_MRDLK));
      if (j == 1) send(mk(3, 0, KIND_CPLDLK));
      drain();
      send(mk(4, j == 1 ? 0 : 3, KIND_MWR));
      held();
      repeat (20) @(posedge clk_sys);
      chk(exp_q.size() == 1 && hold_active === 1'b1, "blocked TLP lost");
      do_reset();
    end
    $display("test hold done");
    close_out();
  end
endmodule
`default_nettype wire
